/* rtl/pcwd_pkg.sv */
// Shared constants and carrier types for the card window decoder
package pcwd_pkg;

	localparam int NUM_WIN = 7;
	localparam int NUM_IO_RST = 2;

	// Register offsets on the byte-wide register port
	localparam logic [11:0] SOCK_CTL1_OFS = 12'h816;
	localparam logic [11:0] GLOB_CTL3_OFS = 12'h925;
	// Window block: offset[11:7] selects it, [6:4] window, [3:0] byte
	localparam logic [4:0] WIN_REGION = 5'h11;
	localparam logic [3:0] WB_CTL = 4'h0;
	localparam logic [3:0] WB_START_LO = 4'h1;
	localparam logic [3:0] WB_START_HI = 4'h2;
	localparam logic [3:0] WB_STOP_LO = 4'h3;
	localparam logic [3:0] WB_STOP_HI = 4'h4;
	localparam logic [3:0] WB_OFS_LO = 4'h5;
	localparam logic [3:0] WB_OFS_HI = 4'h6;
	localparam logic [3:0] WB_UPPER = 4'h7;

	localparam int VIDEO_EN_BIT = 0;
	localparam int VIDEO_ARM_BIT = 7;
	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] CTL3_RST = 8'h00;
	localparam logic [7:0] WIN_CTL_MEM_RST = 8'h00;
	localparam logic [7:0] WIN_CTL_IO_RST = 8'h06;

	typedef enum logic [1:0] {
		SZ_8 = 2'b00,
		SZ_16 = 2'b01,
		SZ_AUTO = 2'b10
	} pcwd_size_type;

	typedef struct packed {
		logic wprot;
		logic attr;
		logic tset;
		pcwd_size_type size;
		logic card_io;
		logic pci_io;
		logic enable;
	} pcwd_ctl_type;

	typedef struct packed {
		pcwd_ctl_type ctl;
		logic [15:0] start;
		logic [15:0] stop;
		logic [15:0] offset;
		logic [7:0] upper;
	} pcwd_win_type;

	typedef struct packed {
		logic valid;
		logic io;
		logic write;
		logic [31:0] addr;
	} pcwd_req_type;

	typedef struct packed {
		logic valid;
		logic io;
		logic write;
		logic attr;
		logic size16;
		logic tset;
		logic [25:0] addr;
	} pcwd_cyc_type;

	typedef struct packed {
		pcwd_win_type [NUM_WIN-1:0] win;
		logic [7:0] ctl1;
		logic [7:0] ctl3;
		logic [7:0] rdata;
		logic claim;
		logic drop;
		logic addr_hi_oe;
		pcwd_cyc_type cyc;
	} pcwd_state_type;

	function automatic pcwd_state_type rst_state();
		pcwd_state_type s;
		s = '0;
		for (int i = 0; i < NUM_WIN; i++)
		begin
			s.win[i].ctl = (i >= NUM_WIN - NUM_IO_RST) ?
				pcwd_ctl_type'(WIN_CTL_IO_RST) :
				pcwd_ctl_type'(WIN_CTL_MEM_RST);
		end
		s.ctl1 = CTL1_RST;
		s.ctl3 = CTL3_RST;
		s.addr_hi_oe = 1'b1;
		return s;
	endfunction : rst_state

	localparam pcwd_state_type ST_RST = rst_state();

endpackage : pcwd_pkg

/* rtl/pcwd_window_decoder.sv */
// Per-socket window decoder and address translator for 16-bit cards
`timescale 1ns/100ps
`default_nettype none

module pcwd_window_decoder
	import pcwd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Byte-wide register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// PCI side decode request and claim
	input wire pcwd_req_type req,
	output logic claim,
	output logic drop,
	// Card side cycle request
	input wire logic card_iois16,
	output pcwd_cyc_type cyc,
	output logic addr_hi_oe
);

	pcwd_state_type st;
	pcwd_state_type next_st;
	logic hit_any;
	logic [2:0] hit_idx;
	pcwd_win_type sel;
	logic win_sel_ok;
	logic [2:0] reg_win;

	function automatic logic win_hit(pcwd_win_type w, pcwd_req_type r);
		logic hit;
		hit = 1'b0;
		if (w.ctl.enable && r.io && w.ctl.pci_io)
		begin
			// Upper I/O space is never decoded by any window
			hit = (r.addr[31:16] == 16'h0000) &&
				(r.addr[15:0] >= w.start) &&
				(r.addr[15:0] <= w.stop);
		end
		else if (w.ctl.enable && !r.io && !w.ctl.pci_io)
		begin
			hit = (r.addr[31:24] == w.upper) &&
				(r.addr[23:12] >= w.start[11:0]) &&
				(r.addr[23:12] <= w.stop[11:0]);
		end
		return hit;
	endfunction : win_hit

	function automatic logic [25:0] xlate(pcwd_win_type w,
		logic [31:0] a);
		logic [25:0] ca;
		if (w.ctl.pci_io)
			ca = {10'h000, a[15:0] + w.offset};
		else
			ca = a[25:0] + {w.offset[13:0], 12'h000};
		return ca;
	endfunction : xlate

	function automatic logic [7:0] win_rd(pcwd_win_type w,
		logic [3:0] b);
		logic [7:0] d;
		case (b)
			WB_CTL: d = w.ctl;
			WB_START_LO: d = w.start[7:0];
			WB_START_HI: d = w.start[15:8];
			WB_STOP_LO: d = w.stop[7:0];
			WB_STOP_HI: d = w.stop[15:8];
			WB_OFS_LO: d = w.offset[7:0];
			WB_OFS_HI: d = w.offset[15:8];
			WB_UPPER: d = w.upper;
			default: d = 8'h00;
		endcase
		return d;
	endfunction : win_rd

	always_comb
	begin
		next_st = st;
		next_st.claim = 1'b0;
		next_st.drop = 1'b0;
		next_st.cyc.valid = 1'b0;
		hit_any = 1'b0;
		hit_idx = 3'h0;
		// Scan downward so the lowest-numbered hit is the one kept
		for (int i = NUM_WIN - 1; i >= 0; i--)
		begin
			if (win_hit(st.win[i], req))
			begin
				hit_any = 1'b1;
				hit_idx = 3'(i);
			end
		end
		sel = st.win[hit_idx];
		if (req.valid && hit_any)
		begin
			next_st.claim = 1'b1;
			if (req.write && sel.ctl.wprot && !sel.ctl.pci_io)
			begin
				// Claimed so the host is not left hanging, card untouched
				next_st.drop = 1'b1;
			end
			else
			begin
				next_st.cyc.valid = 1'b1;
				next_st.cyc.io = sel.ctl.card_io;
				next_st.cyc.write = req.write;
				next_st.cyc.attr = sel.ctl.attr && !sel.ctl.card_io;
				next_st.cyc.tset = sel.ctl.tset;
				next_st.cyc.addr = xlate(sel, req.addr);
				case (sel.ctl.size)
					SZ_8: next_st.cyc.size16 = 1'b0;
					SZ_16: next_st.cyc.size16 = 1'b1;
					SZ_AUTO: next_st.cyc.size16 =
						sel.ctl.card_io && card_iois16;
					default: next_st.cyc.size16 = 1'b0;
				endcase
			end
		end
		reg_win = reg_addr[6:4];
		win_sel_ok = (reg_addr[11:7] == WIN_REGION) &&
			(reg_win < 3'(NUM_WIN)) && (reg_addr[3] == 1'b0);
		if (reg_wr)
		begin
			if (reg_addr == SOCK_CTL1_OFS)
				next_st.ctl1 = reg_wdata;
			else if (reg_addr == GLOB_CTL3_OFS)
				next_st.ctl3 = reg_wdata;
			else if (win_sel_ok)
			begin
				case (reg_addr[3:0])
					WB_CTL: next_st.win[reg_win].ctl = reg_wdata;
					WB_START_LO: next_st.win[reg_win].start[7:0] = reg_wdata;
					WB_START_HI: next_st.win[reg_win].start[15:8] = reg_wdata;
					WB_STOP_LO: next_st.win[reg_win].stop[7:0] = reg_wdata;
					WB_STOP_HI: next_st.win[reg_win].stop[15:8] = reg_wdata;
					WB_OFS_LO: next_st.win[reg_win].offset[7:0] = reg_wdata;
					WB_OFS_HI: next_st.win[reg_win].offset[15:8] = reg_wdata;
					WB_UPPER: next_st.win[reg_win].upper = reg_wdata;
					default: next_st.win[reg_win].upper = st.win[reg_win].upper;
				endcase
			end
		end
		if (reg_rd)
		begin
			if (reg_addr == SOCK_CTL1_OFS)
				next_st.rdata = st.ctl1;
			else if (reg_addr == GLOB_CTL3_OFS)
				next_st.rdata = st.ctl3;
			else if (win_sel_ok)
				next_st.rdata = win_rd(st.win[reg_win], reg_addr[3:0]);
			else
				next_st.rdata = 8'h00;
		end
		// Enable alone is not enough; the global arm bit must agree
		next_st.addr_hi_oe = !(next_st.ctl1[VIDEO_EN_BIT] &&
			next_st.ctl3[VIDEO_ARM_BIT]);
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign claim = st.claim;
	assign drop = st.drop;
	assign cyc = st.cyc;
	assign addr_hi_oe = st.addr_hi_oe;

	// Every check runs on the one system clock and sleeps through reset
	default clocking sys_cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	claim_has_cause_a: assert property (
		claim
		|-> $past(req.valid) && $past(hit_any))
		else $error("claim without a hitting request");

	idle_quiet_a: assert property (
		!req.valid
		|=> !claim && !drop && !cyc.valid)
		else $error("claim or card cycle without a request");

	cyc_claimed_a: assert property (
		cyc.valid
		|-> claim && !drop)
		else $error("card cycle without a claim");

	space_match_a: assert property (
		(req.valid && hit_any)
		|-> sel.ctl.pci_io == req.io)
		else $error("window of the wrong space selected");

	win_enabled_a: assert property (
		(req.valid && hit_any)
		|-> sel.ctl.enable)
		else $error("disabled window selected");

	disabled_silent_a: assert property (
		(req.valid && !hit_any)
		|=> !claim && !cyc.valid)
		else $error("access outside enabled windows was claimed");

	io_above_silent_a: assert property (
		(req.valid && req.io && req.addr[31:16] != 16'h0000)
		|=> !claim)
		else $error("I/O access above 64K was claimed");

	io_range_a: assert property (
		(req.valid && req.io && hit_any)
		|-> (req.addr[15:0] >= sel.start) && (req.addr[15:0] <= sel.stop))
		else $error("I/O claim outside the window range");

	io_addr_low_a: assert property (
		(req.valid && req.io && hit_any)
		|=> cyc.valid && cyc.addr[25:16] == 10'h000)
		else $error("I/O card address above 64K");

	mem_start_a: assert property (
		(req.valid && !req.io && hit_any)
		|-> req.addr[23:12] >= sel.start[11:0])
		else $error("memory claim below the window start");

	mem_stop_a: assert property (
		(req.valid && !req.io && hit_any)
		|-> req.addr[23:12] <= sel.stop[11:0])
		else $error("memory claim above the window end");

	mem_page_a: assert property (
		(req.valid && !req.io && hit_any)
		|-> req.addr[31:24] == sel.upper)
		else $error("memory claim outside the window page");

	// Overlap is a software fault; window 0 must still win it cleanly
	lowest_wins_a: assert property (
		(req.valid && win_hit(st.win[0], req))
		|-> hit_idx == 3'h0)
		else $error("lowest hitting window not selected");

	wprot_drop_a: assert property (
		(req.valid && hit_any && req.write && sel.ctl.wprot &&
		!sel.ctl.pci_io) |=> drop && claim && !cyc.valid)
		else $error("protected write reached the card");

	drop_claimed_a: assert property (
		drop
		|-> claim && !cyc.valid)
		else $error("dropped write not claimed or sent on");

	drop_memory_a: assert property (
		drop
		|-> !$past(req.io))
		else $error("write protect applied to an I/O access");

	read_pass_a: assert property (
		(req.valid && hit_any && !req.write)
		|=> cyc.valid && !cyc.write)
		else $error("read not passed to the card");

	write_pass_a: assert property (
		(req.valid && hit_any && req.write &&
		(sel.ctl.pci_io || !sel.ctl.wprot))
		|=> cyc.valid && cyc.write)
		else $error("unprotected write not passed to the card");

	card_space_a: assert property (
		(req.valid && hit_any && !req.write)
		|=> cyc.io == $past(sel.ctl.card_io))
		else $error("card cycle type differs from the window");

	tset_follow_a: assert property (
		(req.valid && hit_any && !req.write)
		|=> cyc.tset == $past(sel.ctl.tset))
		else $error("timing set differs from the window");

	size_manual_a: assert property (
		(req.valid && hit_any && sel.ctl.size == SZ_16 &&
		!(req.write && sel.ctl.wprot && !sel.ctl.pci_io))
		|=> cyc.valid && cyc.size16)
		else $error("manual 16-bit width not honoured");

	size_eight_a: assert property (
		(req.valid && hit_any && !req.write && sel.ctl.size == SZ_8)
		|=> cyc.valid && !cyc.size16)
		else $error("manual 8-bit width not honoured");

	size_auto_a: assert property (
		(req.valid && hit_any && sel.ctl.size == SZ_AUTO &&
		sel.ctl.card_io) |=> cyc.valid && cyc.size16 == $past(card_iois16))
		else $error("auto width does not follow IOIS16");

	attr_select_a: assert property (
		cyc.valid && cyc.attr
		|-> !cyc.io)
		else $error("attribute select on a card I/O cycle");

	attr_follow_a: assert property (
		(req.valid && hit_any && !req.write && !sel.ctl.card_io)
		|=> cyc.attr == $past(sel.ctl.attr))
		else $error("attribute select differs from the window");

	// The card sees a stable address between cycles, not a moving one
	addr_hold_a: assert property (
		!cyc.valid
		|-> $stable(cyc.addr))
		else $error("card address moved without a card cycle");

	video_float_a: assert property (
		(st.ctl1[VIDEO_EN_BIT] && st.ctl3[VIDEO_ARM_BIT]) == !addr_hi_oe)
		else $error("upper address drive disagrees with bypass bits");

	video_arm_a: assert property (
		(reg_wr && reg_addr == GLOB_CTL3_OFS &&
		reg_wdata[VIDEO_ARM_BIT] && st.ctl1[VIDEO_EN_BIT])
		|=> !addr_hi_oe)
		else $error("armed and enabled bypass left the address driven");

	video_unarmed_a: assert property (
		(!st.ctl3[VIDEO_ARM_BIT] && !(reg_wr && reg_addr == GLOB_CTL3_OFS))
		|=> addr_hi_oe)
		else $error("address floated while bypass not armed");

endmodule : pcwd_window_decoder

`default_nettype wire

/* sim/pcwd_card_model.sv */
// Card-side model: answers the 16-bit I/O indication and counts card cycles
`timescale 1ns/100ps
`default_nettype none
module pcwd_card_model
	import pcwd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Host request and card cycle
	input wire pcwd_req_type req,
	input wire pcwd_cyc_type cyc,
	input wire logic wide_card,
	// Card answers
	output logic card_iois16,
	output logic [7:0] cyc_seen
);
	// Outside an I/O access the line means nothing, so show the inverse
	assign card_iois16 = (req.valid && req.io) ? wide_card : !wide_card;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cyc_seen <= 8'h00;
		else if (cyc.valid)
			cyc_seen <= cyc_seen + 8'h01;
	end
endmodule : pcwd_card_model
`default_nettype wire

/* sim/test_pci_to_card16_window_decoder.sv */
// Self-checking bench for the card window decoder
`timescale 1ns/100ps
`default_nettype none
module test_pci_to_card16_window_decoder
	import pcwd_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	pcwd_req_type req = '0;
	logic claim;
	logic drop;
	logic card_iois16;
	logic wide_card = 1'b0;
	pcwd_cyc_type cyc;
	logic addr_hi_oe;
	logic [7:0] cyc_seen;
	int err_count = 0;
	int total_checks = 0;
	always #10 clk_sys = !clk_sys;
	pcwd_window_decoder pcwd_window_decoder_inst (.clk_sys(clk_sys),
		.rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.req(req), .claim(claim), .drop(drop), .card_iois16(card_iois16),
		.cyc(cyc), .addr_hi_oe(addr_hi_oe));
	pcwd_card_model pcwd_card_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.req(req), .cyc(cyc), .wide_card(wide_card),
		.card_iois16(card_iois16), .cyc_seen(cyc_seen));
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
	endtask : reg_read
	// Control byte goes last so the window never opens half programmed
	task automatic win_set(input logic [11:0] b, input logic [7:0] ctl,
		input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] ofs, input logic [7:0] up);
		reg_write(b + 12'h1, lo[7:0]);
		reg_write(b + 12'h2, lo[15:8]);
		reg_write(b + 12'h3, hi[7:0]);
		reg_write(b + 12'h4, hi[15:8]);
		reg_write(b + 12'h5, ofs[7:0]);
		reg_write(b + 12'h6, ofs[15:8]);
		reg_write(b + 12'h7, up);
		reg_write(b, ctl);
	endtask : win_set
	// exp holds claim, drop, card cycle valid and 16-bit width
	task automatic decode(input logic io, input logic wr,
		input logic [31:0] a, input logic [3:0] exp, input logic [25:0] ca);
		@(posedge clk_sys);
		req <= '{valid: 1'b1, io: io, write: wr, addr: a};
		@(posedge clk_sys);
		req.valid <= 1'b0;
		#1;
		check("claim_drop_cyc", {29'h0, exp[3:1]},
			{29'h0, claim, drop, cyc.valid});
		// Width and address only mean something when a card cycle went out
		if (exp[1])
		begin
			check("size16", {31'h0, exp[0]}, {31'h0, cyc.size16});
			check("card_addr", {6'h0, ca}, {6'h0, cyc.addr});
		end
	endtask : decode
	task automatic test_reset();
		reg_read(12'h880, 8'h00);
		reg_read(12'h8C0, 8'h00);
		reg_read(12'h8D0, 8'h06);
		reg_read(12'h8E0, 8'h06);
		reg_read(12'h816, 8'h00);
		reg_read(12'h925, 8'h00);
		reg_read(12'h8F0, 8'h00);
		decode(1'b1, 1'b0, 32'h0, 4'h0, 26'h0);
	endtask : test_reset
	task automatic test_mem();
		logic [7:0] seen;
		win_set(12'h880, 8'h69, 16'h0100, 16'h0101, 16'h3F00, 8'h40);
		decode(1'b0, 1'b0, 32'h4010_0ABC, 4'hB, 26'h0000ABC);
		check("attr_tset", 32'h3, {30'h0, cyc.attr, cyc.tset});
		decode(1'b0, 1'b1, 32'h4010_1FFF, 4'hB, 26'h0001FFF);
		check("cyc_write", 32'h1, {31'h0, cyc.write});
		check("card_io", 32'h0, {31'h0, cyc.io});
		decode(1'b0, 1'b0, 32'h4010_2000, 4'h0, 26'h0);
		decode(1'b0, 1'b0, 32'h400F_FFFF, 4'h0, 26'h0);
		decode(1'b0, 1'b0, 32'h4110_0ABC, 4'h0, 26'h0);
		decode(1'b1, 1'b0, 32'h4010_0ABC, 4'h0, 26'h0);
		reg_write(12'h880, 8'hE9);
		seen = cyc_seen;
		decode(1'b0, 1'b1, 32'h4010_0010, 4'hC, 26'h0);
		check("card_cycles", {24'h0, seen}, {24'h0, cyc_seen});
		decode(1'b0, 1'b0, 32'h4010_0010, 4'hB, 26'h0000010);
		check("cyc_write", 32'h0, {31'h0, cyc.write});
		reg_write(12'h880, 8'h68);
		decode(1'b0, 1'b0, 32'h4010_0010, 4'h0, 26'h0);
	endtask : test_mem
	task automatic test_io();
		wide_card <= 1'b1;
		win_set(12'h8D0, 8'h17, 16'h03F8, 16'h03FF, 16'h0100, 8'h00);
		decode(1'b1, 1'b0, 32'h03FA, 4'hB, 26'h04FA);
		check("attr_tset", 32'h0, {30'h0, cyc.attr, cyc.tset});
		wide_card <= 1'b0;
		decode(1'b1, 1'b1, 32'h03FF, 4'hA, 26'h04FF);
		check("cyc_write", 32'h1, {31'h0, cyc.write});
		decode(1'b1, 1'b0, 32'h03F7, 4'h0, 26'h0);
		decode(1'b1, 1'b0, 32'h1_03FA, 4'h0, 26'h0);
		decode(1'b0, 1'b0, 32'h03FA, 4'h0, 26'h0);
		reg_write(12'h8D0, 8'h0F);
		decode(1'b1, 1'b0, 32'h03F8, 4'hB, 26'h04F8);
		wide_card <= 1'b1;
		reg_write(12'h8D0, 8'h07);
		decode(1'b1, 1'b0, 32'h03F8, 4'hA, 26'h04F8);
		win_set(12'h8A0, 8'h01, 16'h0100, 16'h0100, 16'h0000, 8'h40);
		win_set(12'h890, 8'h05, 16'h0100, 16'h0100, 16'h0000, 8'h40);
		decode(1'b0, 1'b0, 32'h4010_0004, 4'hA, 26'h0100004);
		check("card_io", 32'h1, {31'h0, cyc.io});
	endtask : test_io
	task automatic test_video();
		check("addr_hi_oe", 32'h1, {31'h0, addr_hi_oe});
		reg_write(12'h816, 8'h01);
		@(posedge clk_sys);
		#1;
		check("addr_hi_oe", 32'h1, {31'h0, addr_hi_oe});
		reg_write(12'h925, 8'h80);
		@(posedge clk_sys);
		#1;
		check("addr_hi_oe", 32'h0, {31'h0, addr_hi_oe});
		reg_read(12'h925, 8'h80);
		reg_write(12'h816, 8'h00);
		@(posedge clk_sys);
		#1;
		check("addr_hi_oe", 32'h1, {31'h0, addr_hi_oe});
	endtask : test_video
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		test_reset();
		test_mem();
		test_io();
		test_video();
		conclude();
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		#(20 * 20000);
		err_count++;
		conclude();
	end
endmodule : test_pci_to_card16_window_decoder
`default_nettype wire
